/* File: logic/srap_host.sv */
// SPI master that reads and writes the 16-bit register map of a device
// through its four-wire serial port.
// Assumes the device samples SDI on rising SCLK and drives SDO on falling SCLK;
// dev_sdo is asynchronous and is synchronised before use.
//
// Behaviour
// RULE1: device drives SDO on falling SCLK, samples SDI on rising SCLK.
// RULE2: every transaction opens with chip select falling, then a 16-bit command.
// RULE3: the port only works while chip select is low; master drives it.
// RULE4: command bits 15..11 always carry pattern 11100.
// RULE5: command bit 10 is one for read, zero for write.
// RULE6: command bits 9..0 give the first register address.
// RULE7: write data words of 16 bits follow the command on SDI.
// RULE8: device increments its pointer for each further write word.
// RULE9: pointer stops at its maximum; later write data is dropped.
// RULE10: a single write clocks exactly 32 bits under chip select.
// RULE11: SCLK may idle at either level between transactions.
// RULE12: a read sends the command, then 16 clocks per data word.
// RULE13: first read bit appears on the falling edge after the command.
// RULE14: device increments its pointer after each 16-bit read word.
// RULE15: reading continues while SCLK runs; raising chip select ends it.
// RULE16: at maximum pointer, reads keep returning the last register.
// RULE17: device keeps SDO high-impedance unless returning read data; the bench model drives the inverse of its last bit instead.
// RULE18: chip select stays low until all requested read bits are shifted.
// RULE19: registers are 16 bits, transferred most significant bit first.
// RULE20: device ignores a transaction with a wrong enable pattern.
// RULE21: device restarts its bit count whenever chip select rises.
`timescale 1ns/100ps
`include "srap_consts.svh"
module srap_host #(
  parameter int LEN_W = 8,
  parameter int HALF_CYC = `SRAP_SCLK_HALF_CYC,
  parameter bit SCLK_IDLE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_rd,
  input wire logic [9:0] req_addr,
  input wire logic [LEN_W-1:0] req_len,
  input wire logic wr_valid,
  input wire logic [15:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic [9:0] rd_addr,
  output logic busy,
  output logic done,
  output logic dev_sclk,
  output logic dev_cs_n,
  output logic dev_sdi,
  input wire logic dev_sdo
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  localparam int FB_W = LEN_W + 6;

  generate
    if (HALF_CYC < `SRAP_SCLK_HALF_MIN) begin : g_bad_half
      $error("HALF_CYC too small for synchronised SDO sampling");
    end
    if (LEN_W < 1 || LEN_W > 16) begin : g_bad_len
      $error("LEN_W out of range");
    end
  endgenerate

  function automatic srap_pkg::srap_addr_t sat_inc(input srap_pkg::srap_addr_t a);
    if (a == `SRAP_ADDR_MAX) begin
      sat_inc = a;
    end else begin
      sat_inc = a + 10'h001;
    end
  endfunction : sat_inc

  // ----------------------------------------------------------------------
  // Pin synchroniser and tick divider
  // ----------------------------------------------------------------------
  logic sdo_s;
  logic tick;
  srap_pkg::srap_state_e state_r;
  srap_pkg::srap_state_e state_nxt;

  srap_sync u_sdo_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(dev_sdo),
    .sync_out(sdo_s)
  );

  srap_tick_gen #(
    .HALF_CYC(HALF_CYC)
  ) u_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .en((state_r != srap_pkg::SRAP_IDLE) && (state_r != srap_pkg::SRAP_LOAD)),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // Transaction state
  // ----------------------------------------------------------------------
  logic rd_mode_r, rd_mode_nxt;
  logic is_cmd_r, is_cmd_nxt;
  logic [LEN_W-1:0] len_r, len_nxt;
  logic [3:0] bit_r, bit_nxt;
  srap_pkg::srap_word_t tx_r, tx_nxt;
  srap_pkg::srap_word_t rx_r, rx_nxt;
  srap_pkg::srap_addr_t ptr_r, ptr_nxt;
  logic sclk_r, sclk_nxt;
  logic cs_n_r, cs_n_nxt;
  logic sdi_r, sdi_nxt;
  logic req_ready_r, req_ready_nxt;
  logic wr_ready_r, wr_ready_nxt;
  logic rd_valid_r, rd_valid_nxt;
  srap_pkg::srap_word_t rd_data_r, rd_data_nxt;
  srap_pkg::srap_addr_t rd_addr_r, rd_addr_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic [FB_W-1:0] edge_cnt_r, edge_cnt_nxt;
  logic [FB_W-1:0] frame_bits_r, frame_bits_nxt;

  always_comb begin
    state_nxt = state_r;
    rd_mode_nxt = rd_mode_r;
    is_cmd_nxt = is_cmd_r;
    len_nxt = len_r;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    ptr_nxt = ptr_r;
    sclk_nxt = sclk_r;
    cs_n_nxt = cs_n_r;
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    rd_addr_nxt = rd_addr_r;
    done_nxt = 1'b0;
    edge_cnt_nxt = edge_cnt_r;
    frame_bits_nxt = frame_bits_r;
    unique case (state_r)
      srap_pkg::SRAP_IDLE: begin
        sclk_nxt = SCLK_IDLE; // [RULE11]
        if (req_valid && req_ready_r) begin
          rd_mode_nxt = req_rd;
          is_cmd_nxt = 1'b1;
          len_nxt = req_len;
          bit_nxt = 4'h0;
          ptr_nxt = req_addr;
          // Command word: enable pattern, direction, start address
          tx_nxt = {`SRAP_EN_PATTERN, req_rd, req_addr}; // [RULE4] [RULE5] [RULE6]
          cs_n_nxt = 1'b0; // [RULE2] [RULE3]
          edge_cnt_nxt = '0;
          frame_bits_nxt = FB_W'({req_len, 4'h0}) + FB_W'(32); // [RULE10] [RULE12]
          state_nxt = srap_pkg::SRAP_SETUP;
        end
      end
      srap_pkg::SRAP_SETUP: begin
        if (tick) begin
          sclk_nxt = 1'b0;
          state_nxt = srap_pkg::SRAP_SHIFT;
        end
      end
      srap_pkg::SRAP_SHIFT: begin
        if (tick && !sclk_r) begin
          // Rising edge: device latches SDI, we latch SDO MSB first
          sclk_nxt = 1'b1; // [RULE1]
          rx_nxt = {rx_r[14:0], sdo_s}; // [RULE19] [RULE13]
          edge_cnt_nxt = edge_cnt_r + FB_W'(1);
          if (bit_r == 4'hf && !is_cmd_r && rd_mode_r) begin
            rd_valid_nxt = 1'b1; // [RULE12]
            rd_data_nxt = {rx_r[14:0], sdo_s};
            rd_addr_nxt = ptr_r; // [RULE16]
          end
        end else if (tick && sclk_r) begin
          sclk_nxt = 1'b0;
          tx_nxt = {tx_r[14:0], 1'b0};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == 4'hf) begin
            is_cmd_nxt = 1'b0;
            if (!is_cmd_r) begin
              ptr_nxt = sat_inc(ptr_r); // [RULE8] [RULE9] [RULE14] [RULE16]
              len_nxt = len_r - LEN_W'(1);
            end
            if (!is_cmd_r && len_r == '0) begin
              // Last word shifted: park SCLK, then release chip select
              sclk_nxt = SCLK_IDLE; // [RULE18] [RULE15]
              state_nxt = srap_pkg::SRAP_HOLD;
            end else if (!rd_mode_r) begin
              state_nxt = srap_pkg::SRAP_LOAD; // [RULE7]
            end else begin
              tx_nxt = `SRAP_RST_WORD;
            end
          end
        end
      end
      srap_pkg::SRAP_LOAD: begin
        // SCLK is held low while the write source stalls
        if (wr_valid && wr_ready_r) begin
          tx_nxt = wr_data; // [RULE7] [RULE19]
          state_nxt = srap_pkg::SRAP_SHIFT;
        end
      end
      srap_pkg::SRAP_HOLD: begin
        if (tick) begin
          cs_n_nxt = 1'b1; // [RULE15] [RULE21]
          state_nxt = srap_pkg::SRAP_GAP;
        end
      end
      srap_pkg::SRAP_GAP: begin
        if (tick) begin
          done_nxt = 1'b1;
          state_nxt = srap_pkg::SRAP_IDLE;
        end
      end
    endcase
    sdi_nxt = cs_n_nxt ? 1'b0 : tx_nxt[15];
    req_ready_nxt = (state_nxt == srap_pkg::SRAP_IDLE);
    wr_ready_nxt = (state_nxt == srap_pkg::SRAP_LOAD);
    busy_nxt = (state_nxt != srap_pkg::SRAP_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= srap_pkg::SRAP_IDLE;
      rd_mode_r <= 1'b0;
      is_cmd_r <= 1'b0;
      len_r <= '0;
      bit_r <= 4'h0;
      tx_r <= `SRAP_RST_WORD;
      rx_r <= `SRAP_RST_WORD;
      ptr_r <= `SRAP_RST_ADDR;
      sclk_r <= SCLK_IDLE;
      cs_n_r <= 1'b1;
      sdi_r <= 1'b0;
      req_ready_r <= 1'b0;
      wr_ready_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= `SRAP_RST_WORD;
      rd_addr_r <= `SRAP_RST_ADDR;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      edge_cnt_r <= '0;
      frame_bits_r <= '0;
    end else begin
      state_r <= state_nxt;
      rd_mode_r <= rd_mode_nxt;
      is_cmd_r <= is_cmd_nxt;
      len_r <= len_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      ptr_r <= ptr_nxt;
      sclk_r <= sclk_nxt;
      cs_n_r <= cs_n_nxt;
      sdi_r <= sdi_nxt;
      req_ready_r <= req_ready_nxt;
      wr_ready_r <= wr_ready_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      rd_addr_r <= rd_addr_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      frame_bits_r <= frame_bits_nxt;
    end
  end

  assign req_ready = req_ready_r;
  assign wr_ready = wr_ready_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign rd_addr = rd_addr_r;
  assign busy = busy_r;
  assign done = done_r;
  assign dev_sclk = sclk_r;
  assign dev_cs_n = cs_n_r;
  assign dev_sdi = sdi_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_SCLK_IDLE_OUTSIDE_CS: assert property ( // [RULE3] [RULE11]
    @(posedge clk_sys) disable iff (!resetn) cs_n_r |-> (sclk_r == SCLK_IDLE))
    else $error("SCLK left idle level while chip select high");

  AST_SDI_STABLE_HIGH: assert property ( // [RULE1]
    @(posedge clk_sys) disable iff (!resetn)
    (state_r == srap_pkg::SRAP_SHIFT && sclk_r && $past(sclk_r)) |-> $stable(sdi_r))
    else $error("SDI changed while SCLK high");

  AST_CS_FALL_CMD: assert property ( // [RULE2]
    @(posedge clk_sys) disable iff (!resetn)
    $fell(cs_n_r) |-> (is_cmd_r && bit_r == 4'h0 && sclk_r == SCLK_IDLE
      && state_r == srap_pkg::SRAP_SETUP))
    else $error("Chip select fell without a fresh command word");

  AST_CMD_PATTERN: assert property ( // [RULE4]
    @(posedge clk_sys) disable iff (!resetn)
    (is_cmd_r && bit_r == 4'h0 && !cs_n_r) |-> (tx_r[`SRAP_EN_MSB:`SRAP_EN_LSB] == `SRAP_EN_PATTERN))
    else $error("Command word lacks enable pattern");

  AST_CMD_DIR_ADDR: assert property ( // [RULE5] [RULE6]
    @(posedge clk_sys) disable iff (!resetn)
    (is_cmd_r && bit_r == 4'h0 && !cs_n_r) |-> (tx_r[`SRAP_RW_BIT] == rd_mode_r
      && tx_r[`SRAP_ADDR_MSB:0] == ptr_r))
    else $error("Command direction or address wrong");

  AST_FRAME_BITS: assert property ( // [RULE10] [RULE12] [RULE7]
    @(posedge clk_sys) disable iff (!resetn) $rose(cs_n_r) |-> (edge_cnt_r == frame_bits_r))
    else $error("Wrong number of SCLK rising edges in frame");

  AST_PTR_INC: assert property ( // [RULE8] [RULE14]
    @(posedge clk_sys) disable iff (!resetn)
    (state_r == srap_pkg::SRAP_SHIFT && tick && sclk_r && bit_r == 4'hf && !is_cmd_r
      && ptr_r != `SRAP_ADDR_MAX) |=> (ptr_r == $past(ptr_r) + 10'h001))
    else $error("Address pointer did not advance after a data word");

  AST_PTR_SAT: assert property ( // [RULE9] [RULE16]
    @(posedge clk_sys) disable iff (!resetn)
    (ptr_r == `SRAP_ADDR_MAX && state_r != srap_pkg::SRAP_IDLE) |=> (ptr_r == `SRAP_ADDR_MAX))
    else $error("Address pointer wrapped");

  AST_RD_UNDER_CS: assert property ( // [RULE18] [RULE15]
    @(posedge clk_sys) disable iff (!resetn) rd_valid_r |-> (!cs_n_r && rd_mode_r) ##1 !rd_valid_r)
    else $error("Read word completed outside chip select");

  AST_DONE_AFTER_CS: assert property ( // [RULE21]
    @(posedge clk_sys) disable iff (!resetn)
    $rose(cs_n_r) |-> ##[1:64] done_r)
    else $error("Done not signalled after chip select release");

endmodule : srap_host

/* File: common/srap_consts.svh */
// Constants for the SPI register access master: command word layout,
// address range and link timing.
// Included by bare name from design files; holds definitions only.
`ifndef SRAP_CONSTS_SVH
`define SRAP_CONSTS_SVH

// ----------------------------------------------------------------------
// Command word layout
// ----------------------------------------------------------------------
`define SRAP_WORD_BITS 16
`define SRAP_EN_MSB 15
`define SRAP_EN_LSB 11
`define SRAP_EN_PATTERN 5'h1c
`define SRAP_RW_BIT 10
`define SRAP_ADDR_MSB 9
`define SRAP_ADDR_MAX 10'h3ff
`define SRAP_DIR_READ 1'h1
`define SRAP_DIR_WRITE 1'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SRAP_CLK_PERIOD_NS 5
`define SRAP_SCLK_HALF_NS 20
`define SRAP_SCLK_HALF_CYC ((`SRAP_SCLK_HALF_NS + `SRAP_CLK_PERIOD_NS - 1) / `SRAP_CLK_PERIOD_NS)
`define SRAP_SCLK_HALF_MIN 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SRAP_RST_WORD 16'h0000
`define SRAP_RST_ADDR 10'h000

`endif

/* File: common/srap_pkg.sv */
// Types shared by the SPI register access master.
// Assumes nothing beyond a SystemVerilog compiler.
package srap_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRAP_IDLE,
    SRAP_SETUP,
    SRAP_SHIFT,
    SRAP_LOAD,
    SRAP_HOLD,
    SRAP_GAP
  } srap_state_e;

  typedef logic [15:0] srap_word_t;
  typedef logic [9:0] srap_addr_t;

endpackage : srap_pkg

/* File: logic/srap_sync.sv */
// Two-flop synchroniser for a level arriving from a pin.
// Assumes the input is free of glitches wider than a clock period.
`timescale 1ns/100ps
module srap_sync (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meta_r <= 1'h0;
      sync_r <= 1'h0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : srap_sync

/* File: logic/srap_tick_gen.sv */
// Half-period tick divider for the serial clock.
// Counts while enabled; restarts from zero whenever enable drops.
`timescale 1ns/100ps
module srap_tick_gen #(
  parameter int HALF_CYC = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic en,
  output logic tick
);

  localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  generate
    if (HALF_CYC < 1) begin : g_bad_half
      $error("HALF_CYC must be at least one");
    end
  endgenerate

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  always_comb begin
    if (!en || cnt_r == LAST) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick = en && (cnt_r == LAST);

endmodule : srap_tick_gen

/* File: bench/srap_dev_model.sv */
// Behavioural device at the far end of the serial port: a 1024 x 16 register map.
// Assumes SCLK, CS_N and SDI come from the host under test; SDO is resolved here.
`timescale 1ns/100ps
module srap_dev_model (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic slow,
  output logic sdo
);
  // ----------------------------------------------------------------------
  // Register map and transfer state
  // ----------------------------------------------------------------------
  logic [15:0] mem [0:1023];
  logic [15:0] shreg;
  logic [15:0] cmd;
  logic [9:0] ptr;
  logic sdo_d;
  logic drive;
  logic full;
  int nrise;
  int last_bits;
  int rbit;

  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 16'(i * 40503 + 4660);
    {shreg, cmd, ptr, sdo_d, drive, full} = '0;
    nrise = 0;
    last_bits = 0;
    rbit = 0;
  end

  // ----------------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------------
  always @(negedge cs_n) begin
    nrise = 0;
    rbit = 0;
    full = 1'b0;
    cmd = 16'h0000;
  end

  always @(posedge cs_n) begin
    last_bits = nrise;
    drive = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Shift in: command, then write words
  // ----------------------------------------------------------------------
  always @(posedge sclk) begin
    if (!cs_n) begin
      shreg = {shreg[14:0], sdi};
      nrise++;
      if (nrise == 16) begin
        cmd = shreg;
        ptr = shreg[9:0];
      end else if (nrise % 16 == 0 && cmd[15:10] == 6'b111000 && !full) begin
        mem[ptr] = shreg;
        if (ptr == 10'h3ff) full = 1'b1;
        else ptr++;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Shift out: read words, optionally late within the allowed time
  // ----------------------------------------------------------------------
  always @(negedge sclk) begin
    if (!cs_n && nrise >= 16 && cmd[15:10] == 6'b111001) begin
      drive = 1'b1;
      sdo_d <= #(slow ? 4 : 0) mem[ptr][15 - rbit];
      rbit++;
      if (rbit == 16) begin
        rbit = 0;
        if (ptr != 10'h3ff) ptr++;
      end
    end
  end

  // Released line shows the inverse of the last bit so stale data never matches
  assign sdo = drive ? sdo_d : ~sdo_d;

endmodule : srap_dev_model

/* File: bench/srap_host_test.sv */
// Self-checking bench for the serial register access master against a device model.
// Assumes the host, its helpers, the constants header and the device model are compiled first.
`timescale 1ns/100ps
module srap_host_test;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk_sys;
  logic resetn;
  logic req_valid;
  logic req_ready;
  logic req_rd;
  logic [9:0] req_addr;
  logic [7:0] req_len;
  logic wr_valid;
  logic [15:0] wr_data;
  logic wr_ready;
  logic rd_valid;
  logic [15:0] rd_data;
  logic [9:0] rd_addr;
  logic busy;
  logic done;
  logic dev_sclk;
  logic dev_cs_n;
  logic dev_sdi;
  logic dev_sdo;
  logic slow;
  logic [15:0] exp_mem [0:1023];
  logic [15:0] wq [$];
  logic [9:0] addr;
  int n;
  int bad_count;
  int samples_checked;
  int cycles;

  srap_host #(.LEN_W(8), .HALF_CYC(4), .SCLK_IDLE(1'b0)) u_srap_host (
    .clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
    .req_rd(req_rd), .req_addr(req_addr), .req_len(req_len), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_addr(rd_addr), .busy(busy), .done(done), .dev_sclk(dev_sclk), .dev_cs_n(dev_cs_n),
    .dev_sdi(dev_sdi), .dev_sdo(dev_sdo)
  );

  srap_dev_model u_srap_dev_model (
    .sclk(dev_sclk), .cs_n(dev_cs_n), .sdi(dev_sdi), .slow(slow), .sdo(dev_sdo)
  );

  // ----------------------------------------------------------------------
  // Clock, timeout, reporting
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic fill(input int cnt);
    wq.delete();
    repeat (cnt) wq.push_back(16'($urandom));
  endtask : fill

  // ----------------------------------------------------------------------
  // One transaction: request, feed or collect words, then compare
  // ----------------------------------------------------------------------
  task automatic run(input logic rd, input logic [9:0] a, input int cnt);
    int w;
    int got;
    logic [9:0] p;
    logic full;
    logic tk;
    w = 0;
    got = 0;
    p = a;
    full = 1'b0;
    @(posedge clk_sys);
    while (req_ready !== 1'b1) @(posedge clk_sys);
    req_valid <= 1'b1;
    req_rd <= rd;
    req_addr <= a;
    req_len <= 8'(cnt - 1);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    do begin
      @(posedge clk_sys);
      tk = wr_valid && wr_ready;
      if (tk === 1'b1) begin
        if (!full) exp_mem[p] = wq[w];
        if (p == 10'h3ff) full = 1'b1;
        else p++;
        w++;
      end
      if (!rd && (tk === 1'b1 || wr_valid !== 1'b1)) begin
        wr_valid <= (w < cnt) && ($urandom_range(3) != 0);
        wr_data <= (w < cnt) ? wq[w] : 16'h0000;
      end
      if (rd_valid === 1'b1) begin
        check(rd_data, exp_mem[p]);
        check(rd_addr, p);
        check(busy, 1'b1);
        check(dev_cs_n, 1'b0);
        got++;
        if (p != 10'h3ff) p++;
      end
    end while (done !== 1'b1);
    check(busy, 1'b0);
    check(req_ready, 1'b1);
    check(dev_cs_n, 1'b1);
    check(rd ? got : w, cnt);
    check(u_srap_dev_model.last_bits, 16 * (cnt + 1));
    for (int i = 0; i < 1024; i++) check(u_srap_dev_model.mem[i], exp_mem[i]);
  endtask : run

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {resetn, req_valid, req_rd, req_addr, req_len, wr_valid, wr_data, slow} = '0;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(94));
    for (int i = 0; i < 1024; i++) exp_mem[i] = 16'(i * 40503 + 4660);
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    check(dev_cs_n, 1'b1);
    addr = 10'($urandom);
    fill(1);
    run(1'b0, addr, 1);
    run(1'b1, addr, 1);
    fill(6);
    run(1'b0, 10'h3fc, 6);
    run(1'b1, 10'h3fd, 5);
    // Reset in mid-command must leave the map alone and the next frame clean
    while (req_ready !== 1'b1) @(posedge clk_sys);
    req_valid <= 1'b1;
    req_rd <= 1'b0;
    req_addr <= 10'h010;
    req_len <= 8'h00;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    repeat (60) @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    check(dev_cs_n, 1'b1);
    fill(2);
    run(1'b0, 10'h010, 2);
    for (int t = 0; t < 8; t++) begin
      slow = t[0];
      n = 1 + $urandom_range(3);
      addr = 10'($urandom);
      fill(n);
      run(1'($urandom), addr, n);
    end
    give_verdict();
  end

endmodule : srap_host_test
